// ===== bec_cfg.svh
`ifndef BEC_CFG_SVH
`define BEC_CFG_SVH
`define BEC_CTRL_OFS       32'h0000_8000
`define BEC_STAT_OFS       32'h0000_8004
`define BEC_STRIDE_OFS     32'h0000_8014
`define BEC_SIZE_OFS       32'h0000_8018
`define BEC_CTRL_RST       32'h0000_0000
`define BEC_STRIDE_RST     16'h0000
`define BEC_SIZE_RST       16'h0000
`define BEC_START_BIT      0
`define BEC_SRC_LIN_BIT    16
`define BEC_DST_LIN_BIT    17
`define BEC_FMT_BIT        18
`define BEC_BUSY_BIT       0
`endif

// ===== bec_pkg.sv
package bec_pkg;
    typedef enum logic [1:0] {
        BEC_IDLE = 2'b01,
        BEC_RUN  = 2'b10
    } bec_state_t;
endpackage : bec_pkg

// ===== bec_top.sv
// Behaviour
// - Registers at 8000h, control resets to zero
// - Format bit selects 8 or 16 bpp
// - Destination linear bit: contiguous versus rectangle
// - Source linear bit: contiguous versus rectangle
// - Rectangles step lines by offset register
// - Writing one to start bit launches operation; the engine ignores it while busy
// - Busy reads one while running, zero after
`timescale 1ns/10ps
`default_nettype none
`include "bec_cfg.svh"
module bec_top
    import bec_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             bpp16_out,
    output logic             src_linear_out,
    output logic             dst_linear_out,
    output logic      [31:0] src_addr_out,
    output logic      [31:0] dst_addr_out,
    output logic             busy_out
);
    bec_state_t  state_q, state_d;
    logic        fmt_q, fmt_d;
    logic        slin_q, slin_d;
    logic        dlin_q, dlin_d;
    logic [15:0] stride_q, stride_d;
    logic [15:0] size_q, size_d;
    logic [15:0] col_q, col_d;
    logic [15:0] row_q, row_d;
    logic [31:0] sline_q, sline_d;
    logic [31:0] dline_q, dline_d;
    logic [31:0] sa_q, sa_d;
    logic [31:0] da_q, da_d;
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic        acc;
    logic        wr;
    logic        start;
    logic        line_end;
    logic        last;
    logic [31:0] step;

    localparam logic [31:0] CTRL_RST = `BEC_CTRL_RST;

    // Next address along a line or across to the next line
    function automatic logic [31:0] bec_next(input logic lin, input logic eol,
                                             input logic [31:0] cur, input logic [31:0] line,
                                             input logic [15:0] strd, input logic [31:0] inc);
        if (!lin && eol)
            bec_next = line + {16'h0000, strd};
        else
            bec_next = cur + inc;
    endfunction : bec_next

    assign acc      = psel_in && penable_in;
    assign wr       = acc && pwrite_in;
    assign start    = wr && (paddr_in == `BEC_CTRL_OFS) && pwdata_in[`BEC_START_BIT];
    assign step     = fmt_q ? 32'h0000_0002 : 32'h0000_0001;
    assign line_end = (col_q == 16'h0000);
    assign last     = line_end && (row_q == 16'h0000);

    // Control, stride and size registers
    always_comb
    begin
        fmt_d    = fmt_q;
        slin_d   = slin_q;
        dlin_d   = dlin_q;
        stride_d = stride_q;
        size_d   = size_q;
        if (wr)
        begin
            case (paddr_in)
                `BEC_CTRL_OFS:
                begin
                    fmt_d  = pwdata_in[`BEC_FMT_BIT];
                    dlin_d = pwdata_in[`BEC_DST_LIN_BIT];
                    slin_d = pwdata_in[`BEC_SRC_LIN_BIT];
                end
                `BEC_STRIDE_OFS: stride_d = pwdata_in[15:0];
                `BEC_SIZE_OFS:   size_d   = pwdata_in[15:0];
                default:         size_d   = size_q;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            fmt_q    <= CTRL_RST[`BEC_FMT_BIT];
            slin_q   <= CTRL_RST[`BEC_SRC_LIN_BIT];
            dlin_q   <= CTRL_RST[`BEC_DST_LIN_BIT];
            stride_q <= `BEC_STRIDE_RST;
            size_q   <= `BEC_SIZE_RST;
        end
        else
        begin
            fmt_q    <= fmt_d;
            slin_q   <= slin_d;
            dlin_q   <= dlin_d;
            stride_q <= stride_d;
            size_q   <= size_d;
        end
    end

    // Read data and read error flag captured in the setup phase; write error decoded in the access phase
    always_comb
    begin
        rdata_d = rdata_q;
        err_d   = 1'b0;
        if (wr)
        begin
            case (paddr_in)
                `BEC_CTRL_OFS:   err_d = 1'b0;
                `BEC_STRIDE_OFS: err_d = 1'b0;
                `BEC_SIZE_OFS:   err_d = 1'b0;
                default:         err_d = 1'b1;
            endcase
        end
        else if (psel_in && !penable_in && !pwrite_in)
        begin
            case (paddr_in)
                `BEC_CTRL_OFS:   rdata_d = {13'h0, fmt_q, dlin_q, slin_q, 16'h0000};
                `BEC_STAT_OFS:   rdata_d = {31'h0, state_q == BEC_RUN};
                `BEC_STRIDE_OFS: rdata_d = {16'h0000, stride_q};
                `BEC_SIZE_OFS:   rdata_d = {16'h0000, size_q};
                default:         rdata_d = 32'h0000_0000;
            endcase
            err_d = !(paddr_in == `BEC_CTRL_OFS || paddr_in == `BEC_STAT_OFS ||
                      paddr_in == `BEC_STRIDE_OFS || paddr_in == `BEC_SIZE_OFS);
        end
        else if (acc)
        begin
            err_d = err_q;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // Pixel walk over size plus one lines of size plus one pixels
    always_comb
    begin
        state_d = state_q;
        col_d   = col_q;
        row_d   = row_q;
        sline_d = sline_q;
        dline_d = dline_q;
        sa_d    = sa_q;
        da_d    = da_q;
        case (state_q)
            BEC_IDLE:
            begin
                if (start)
                begin
                    state_d = BEC_RUN;
                    col_d   = size_q;
                    row_d   = size_q;
                    sa_d    = 32'h0000_0000;
                    da_d    = 32'h0000_0000;
                    sline_d = 32'h0000_0000;
                    dline_d = 32'h0000_0000;
                end
            end
            // Start while running is ignored
            BEC_RUN:
            begin
                if (last)
                begin
                    state_d = BEC_IDLE;
                end
                else
                begin
                    sa_d  = bec_next(slin_q, line_end, sa_q, sline_q, stride_q, step);
                    da_d  = bec_next(dlin_q, line_end, da_q, dline_q, stride_q, step);
                    col_d = line_end ? size_q : col_q - 16'h0001;
                    if (line_end)
                    begin
                        row_d   = row_q - 16'h0001;
                        sline_d = slin_q ? sa_q + step : sline_q + {16'h0000, stride_q};
                        dline_d = dlin_q ? da_q + step : dline_q + {16'h0000, stride_q};
                    end
                end
            end
            default: state_d = BEC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= BEC_IDLE;
            col_q   <= 16'h0000;
            row_q   <= 16'h0000;
            sline_q <= 32'h0000_0000;
            dline_q <= 32'h0000_0000;
            sa_q    <= 32'h0000_0000;
            da_q    <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            col_q   <= col_d;
            row_q   <= row_d;
            sline_q <= sline_d;
            dline_q <= dline_d;
            sa_q    <= sa_d;
            da_q    <= da_d;
        end
    end

    assign prdata_out     = (acc && !pwrite_in) ? rdata_q : 32'h0000_0000;
    assign pready_out     = 1'b1;
    assign pslverr_out    = acc && (pwrite_in ? err_d : err_q);
    assign bpp16_out      = fmt_q;
    assign src_linear_out = slin_q;
    assign dst_linear_out = dlin_q;
    assign src_addr_out   = sa_q;
    assign dst_addr_out   = da_q;
    assign busy_out       = (state_q == BEC_RUN);

    ctrl_reset_a: assert property (@(posedge core_clk_in) $rose(reset_n_in) |-> !fmt_q && !slin_q && !dlin_q)
        else $error("control not cleared by reset");
    start_busy_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (start && !busy_out) |=> busy_out)
        else $error("start did not raise busy");
    busy_read_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (psel_in && !penable_in && !pwrite_in && paddr_in == `BEC_STAT_OFS) |=> rdata_q[0] == $past(busy_out))
        else $error("status busy mismatch");
    ctrl_zero_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (acc && !pwrite_in && paddr_in == `BEC_CTRL_OFS) |-> {prdata_out[31:19], prdata_out[15:0]} == 29'h0)
        else $error("start bit read back");
    fmt_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !line_end && dlin_q) |=> da_q == $past(da_q) + ($past(fmt_q) ? 32'h2 : 32'h1))
        else $error("pixel step wrong");
    dst_rect_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && line_end && !last && !dlin_q) |=> da_q == $past(dline_q) + {16'h0000, $past(stride_q)})
        else $error("destination line step wrong");
    src_rect_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && line_end && !last && !slin_q) |=> sa_q == $past(sline_q) + {16'h0000, $past(stride_q)})
        else $error("source line step wrong");
    src_lin_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !last && slin_q) |=> sa_q == $past(sa_q) + $past(step))
        else $error("source linear not contiguous");
    reset_idle_a: assert property (@(posedge core_clk_in)
        !reset_n_in |=> !busy_out && src_addr_out == 32'h0 && dst_addr_out == 32'h0)
        else $error("reset did not stop the engine");
    fmt_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (wr && paddr_in == `BEC_CTRL_OFS) |=> bpp16_out == $past(pwdata_in[`BEC_FMT_BIT]))
        else $error("format bit not taken");
    dst_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (wr && paddr_in == `BEC_CTRL_OFS) |=> dst_linear_out == $past(pwdata_in[`BEC_DST_LIN_BIT]))
        else $error("destination linear bit not taken");
    src_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (wr && paddr_in == `BEC_CTRL_OFS) |=> src_linear_out == $past(pwdata_in[`BEC_SRC_LIN_BIT]))
        else $error("source linear bit not taken");
    dst_lin_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !last && dlin_q) |=> da_q == $past(da_q) + $past(step))
        else $error("destination linear not contiguous");
    src_pixel_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !line_end && !slin_q) |=> sa_q == $past(sa_q) + ($past(fmt_q) ? 32'h2 : 32'h1))
        else $error("source pixel step wrong");
    dst_pixel_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !line_end && !dlin_q) |=> da_q == $past(da_q) + ($past(fmt_q) ? 32'h2 : 32'h1))
        else $error("destination pixel step wrong");
    start_load_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (start && !busy_out) |=> src_addr_out == 32'h0 && dst_addr_out == 32'h0)
        else $error("start did not load the walk");
    busy_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && !last) |=> busy_out)
        else $error("busy dropped early");
    busy_end_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (busy_out && last) |=> !busy_out)
        else $error("busy not cleared at end");
    idle_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!busy_out && !start) |=> !busy_out)
        else $error("engine ran without start");
    stat_zero_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (acc && !pwrite_in && paddr_in == `BEC_STAT_OFS) |-> prdata_out[31:1] == 31'h0)
        else $error("status upper bits not zero");
    stride_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (wr && paddr_in == `BEC_STRIDE_OFS) |=> stride_q == $past(pwdata_in[15:0]))
        else $error("line offset not taken");
endmodule : bec_top
`default_nettype wire

// ===== test_blit_engine_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "bec_cfg.svh"
module test_blit_engine_control;
    logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic        bpp16, src_lin, dst_lin, busy;
    logic [31:0] paddr, pwdata, prdata, rd, src_addr, dst_addr;
    int          miscompares = 0, n_tests = 0, busy_cnt = 0, c0, i;
    // Control writes and the word that must read back
    logic [31:0] row_wd [5] = '{32'h0004_0000, 32'h0002_0000, 32'h0001_0000, 32'hffff_fffe, 32'h0000_0000};
    logic [31:0] row_rd [5] = '{32'h0004_0000, 32'h0002_0000, 32'h0001_0000, 32'h0007_0000, 32'h0000_0000};

    bec_top u_bec_top (.core_clk_in(core_clk), .reset_n_in(reset_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .bpp16_out(bpp16), .src_linear_out(src_lin), .dst_linear_out(dst_lin),
        .src_addr_out(src_addr), .dst_addr_out(dst_addr), .busy_out(busy));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; answer taken at the edge where pready is high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready === 1'b1)
        begin
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
        else
        begin
            miscompares++;
            finish_test();
        end
    endtask : apb

    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr   = 32'h0;
        pwdata  = 32'h0;
        reset_n = 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(1'b0, `BEC_CTRL_OFS, 32'h0, rd, err);
        chk("ctrl reset", `BEC_CTRL_RST, rd);
        chk("flags reset", 32'h0, {28'h0, busy, bpp16, dst_lin, src_lin});
        for (i = 0; i < 5; i++)
        begin
            apb(1'b1, `BEC_CTRL_OFS, row_wd[i], rd, err);
            apb(1'b0, `BEC_CTRL_OFS, 32'h0, rd, err);
            chk("ctrl read", row_rd[i], rd);
            chk("mode pins", {29'h0, row_rd[i][18:16]}, {29'h0, bpp16, dst_lin, src_lin});
        end
        apb(1'b0, 32'h0000_8008, 32'h0, rd, err);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, `BEC_STAT_OFS, 32'h1, rd, err);
        chk("status write", 32'h1, {31'h0, err});
        apb(1'b1, `BEC_SIZE_OFS, 32'h3, rd, err);
        apb(1'b1, `BEC_STRIDE_OFS, 32'h10, rd, err);
        c0 = busy_cnt;
        apb(1'b1, `BEC_CTRL_OFS, 32'h0000_0001, rd, err);
        apb(1'b0, `BEC_STAT_OFS, 32'h0, rd, err);
        chk("busy running", 32'h1, rd);
        apb(1'b0, `BEC_CTRL_OFS, 32'h0, rd, err);
        chk("start reads zero", 32'h0, rd);
        apb(1'b1, `BEC_CTRL_OFS, 32'h0000_0001, rd, err);
        rd = 32'h1;
        for (i = 0; i < 40 && rd[0] !== 1'b0; i++) apb(1'b0, `BEC_STAT_OFS, 32'h0, rd, err);
        chk("busy done", 32'h0, rd);
        chk("run length", 32'd16, busy_cnt - c0);
        // Rectangles: last pixel at three lines of 10h plus three bytes
        chk("src end rect", 32'h0000_0033, src_addr);
        chk("dst end rect", 32'h0000_0033, dst_addr);
        // Linear at 16 bpp: fifteen steps of two bytes
        apb(1'b1, `BEC_CTRL_OFS, 32'h0007_0001, rd, err);
        rd = 32'h1;
        for (i = 0; i < 40 && rd[0] !== 1'b0; i++) apb(1'b0, `BEC_STAT_OFS, 32'h0, rd, err);
        chk("busy done lin", 32'h0, rd);
        chk("src end lin", 32'h0000_001e, src_addr);
        chk("dst end lin", 32'h0000_001e, dst_addr);
        // Reset in the middle of a run
        apb(1'b1, `BEC_CTRL_OFS, 32'h0007_0001, rd, err);
        repeat (5) @(posedge core_clk);
        chk("busy mid run", 32'h1, {31'h0, busy});
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        chk("reset busy", 32'h0, {31'h0, busy});
        chk("reset addr", 32'h0, src_addr);
        apb(1'b0, `BEC_CTRL_OFS, 32'h0, rd, err);
        chk("reset ctrl", `BEC_CTRL_RST, rd);
        finish_test();
    end
endmodule : test_blit_engine_control
`default_nettype wire
